// ==== rtl/aplm_limit_monitor.sv ====
`include "aplm_map.svh"
module aplm_limit_monitor #(
    parameter int REG_COUNT        = 4,
    parameter int MIN_RAMP_DEFAULT = `APLM_MIN_RAMP_CYCLES
) (
    input  wire logic                      i_clock,
    input  wire logic                      i_reset,
    // parameter interface
    input  wire logic                      i_param_write,
    input  wire logic                      i_config_write,
    input  wire logic [15:0]               i_config_data,
    input  wire logic                      i_threshold_write,
    input  wire logic [1:0]                i_threshold_index,
    input  wire logic [31:0]               i_threshold_data,
    input  wire logic [31:0]               i_max_travel_speed,
    input  wire logic [31:0]               i_min_ramp_time,
    input  wire logic [31:0]               i_max_accel,
    input  wire aplm_pkg::aplm_accel_unit_t i_accel_unit,
    input  wire logic [31:0]               i_target_window,
    input  wire logic [31:0]               i_wrap_range_start,
    input  wire logic [31:0]               i_wrap_range_end,
    input  wire logic                      i_modulo_axis,
    input  wire logic                      i_amp_enabled,
    // motion task generator and position controller
    input  wire logic                      i_task_valid,
    input  wire aplm_pkg::aplm_task_t      i_task,
    input  wire logic                      i_control_tick,
    input  wire logic [31:0]               i_actual_position,
    input  wire logic [31:0]               i_position_step,
    output aplm_pkg::aplm_limited_t        o_task,
    output logic                           o_task_valid,
    output logic                           o_task_error,
    output logic                           o_in_position,
    output logic [31:0]                    o_setpoint,
    output aplm_pkg::aplm_inhibit_t        o_inhibit,
    output logic [REG_COUNT-1:0]           o_threshold_flag,
    output logic [15:0]                    o_position_register_config,
    output logic [31:0]                    o_max_travel_speed,
    output logic [31:0]                    o_min_ramp_time,
    output logic [31:0]                    o_target_window,
    output logic [31:0]                    o_wrap_range_start,
    output logic [31:0]                    o_wrap_range_end
);
    import aplm_pkg::*;

    localparam logic [31:0] MIN_RAMP_RST = 32'(MIN_RAMP_DEFAULT);

    // parameter set
    logic [15:0]   position_register_config;
    logic [31:0]   pos_threshold_n [REG_COUNT];
    logic [31:0]   max_travel_speed;
    logic [31:0]   min_ramp_time;
    logic [31:0]   target_window;
    logic [31:0]   wrap_range_start;
    logic [31:0]   wrap_range_end;
    logic [15:0]   next_config;
    logic [31:0]   next_speed;
    logic [31:0]   next_ramp;
    logic [31:0]   next_window;
    logic [31:0]   next_wrap_start;
    logic [31:0]   next_wrap_end;
    logic          config_allowed;
    logic [31:0]   ramp_from_accel;

    // threshold setup accepted only while the amplifier is disabled
    assign config_allowed = !i_amp_enabled;

    // ramp limit from acceleration: time = speed / accel, floor 1
    always_comb begin
        ramp_from_accel = (i_max_accel == 32'h00000000) ? 32'hFFFFFFFF :
            i_max_travel_speed / i_max_accel;
        if (ramp_from_accel == 32'h00000000) begin
            ramp_from_accel = 32'h00000001;
        end
    end

    // parameter next values
    always_comb begin
        next_config     = position_register_config;
        next_speed      = max_travel_speed;
        next_ramp       = min_ramp_time;
        next_window     = target_window;
        next_wrap_start = wrap_range_start;
        next_wrap_end   = wrap_range_end;
        if (i_config_write && config_allowed) begin
            // reserved bits held at zero
            next_config = i_config_data & ~`APLM_CFG_RESERVED;
        end
        if (i_param_write) begin
            next_speed      = i_max_travel_speed;
            next_ramp       = (i_accel_unit == APLM_UNIT_ACCEL) ?
                ramp_from_accel : i_min_ramp_time;
            next_window     = i_target_window;
            next_wrap_start = i_wrap_range_start;
            next_wrap_end   = i_wrap_range_end;
        end
    end

    // parameter registers
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            position_register_config <= `APLM_RST_CONFIG;
            max_travel_speed         <= `APLM_RST_MAX_SPEED;
            min_ramp_time            <= MIN_RAMP_RST;
            target_window            <= `APLM_RST_WINDOW;
            wrap_range_start         <= `APLM_RST_WRAP_START;
            wrap_range_end           <= `APLM_RST_WRAP_END;
        end else begin
            position_register_config <= next_config;
            max_travel_speed         <= next_speed;
            min_ramp_time            <= next_ramp;
            target_window            <= next_window;
            wrap_range_start         <= next_wrap_start;
            wrap_range_end           <= next_wrap_end;
        end
    end

    // thresholds as a small array, one write port
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                pos_threshold_n[i] <= `APLM_RST_THRESHOLD;
            end
        end else if (i_threshold_write && config_allowed) begin
            pos_threshold_n[i_threshold_index] <= i_threshold_data;
        end
    end

    assign o_position_register_config = position_register_config;
    assign o_max_travel_speed         = max_travel_speed;
    assign o_min_ramp_time            = min_ramp_time;
    assign o_target_window            = target_window;
    assign o_wrap_range_start         = wrap_range_start;
    assign o_wrap_range_end           = wrap_range_end;

    // four comparators, limit mode decided below
    genvar g;
    generate
        for (g = 0; g < REG_COUNT; g++) begin : g_cmp
            aplm_pos_compare u_cmp (
                .i_clock     (i_clock),
                .i_reset     (i_reset),
                .i_sample    (i_control_tick),
                .i_config    (position_register_config[g*4 +: 4]),
                .i_threshold (pos_threshold_n[g]),
                .i_position  (i_actual_position),
                .o_flag      (o_threshold_flag[g])
            );
        end
    endgenerate

    // task limiting
    aplm_limited_t next_task;
    logic          next_task_valid;
    logic          next_task_error;
    logic          target_outside;

    always_comb begin
        target_outside = $signed(i_task.target) < $signed(wrap_range_start)
            || $signed(i_task.target) > $signed(wrap_range_end);
        next_task       = o_task;
        next_task_valid = 1'b0;
        next_task_error = 1'b0;
        if (i_task_valid) begin
            if (i_modulo_axis && i_task.absolute && target_outside) begin
                next_task_error = 1'b1;
            end else begin
                next_task_valid   = 1'b1;
                next_task.target  = i_task.target;
                next_task.velocity = (i_task.velocity > max_travel_speed) ?
                    max_travel_speed : i_task.velocity;
                next_task.accel_time = (i_task.accel_time < min_ramp_time) ?
                    min_ramp_time : i_task.accel_time;
                next_task.brake_time = (i_task.brake_time < min_ramp_time) ?
                    min_ramp_time : i_task.brake_time;
            end
        end
    end

    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            o_task       <= '0;
            o_task_valid <= 1'b0;
            o_task_error <= 1'b0;
        end else begin
            o_task       <= next_task;
            o_task_valid <= next_task_valid;
            o_task_error <= next_task_error;
        end
    end

    // setpoint, in-position and limit supervision
    logic [31:0]   next_setpoint;
    logic          next_in_position;
    aplm_inhibit_t next_inhibit;
    logic [32:0]   distance;
    logic [32:0]   stepped;
    logic          limit1_hit;
    logic          limit2_hit;

    // limit mode only on registers 1 and 2; flags follow compare result
    assign limit1_hit = position_register_config[`APLM_CFG_LIMIT_BIT]
        && position_register_config[`APLM_CFG_ENABLE_BIT]
        && $signed(i_actual_position) < $signed(pos_threshold_n[0]);
    assign limit2_hit = position_register_config[4 + `APLM_CFG_LIMIT_BIT]
        && position_register_config[4 + `APLM_CFG_ENABLE_BIT]
        && $signed(i_actual_position) > $signed(pos_threshold_n[1]);

    always_comb begin
        distance = {o_task.target[31], o_task.target}
            - {i_actual_position[31], i_actual_position};
        if (distance[32]) begin
            distance = 33'(0) - distance;
        end
        stepped = {1'b0, o_setpoint} + {1'b0, i_position_step};
        next_setpoint    = o_setpoint;
        next_in_position = o_in_position;
        next_inhibit     = o_inhibit;
        if (i_control_tick) begin
            next_in_position = distance <= {1'b0, target_window};
            next_inhibit.inhibit_neg = limit1_hit;
            next_inhibit.inhibit_pos = limit2_hit;
            // brake on emergency ramp then hold under torque
            next_inhibit.emergency_stop = limit1_hit || limit2_hit;
            // keep approaching target regardless of in-position
            next_setpoint = o_task.target;
            if (i_modulo_axis) begin
                next_setpoint = stepped[31:0];
                if ($signed(stepped[31:0]) >= $signed(wrap_range_end)) begin
                    next_setpoint = wrap_range_start;
                end
            end
        end
    end

    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            o_setpoint    <= 32'h00000000;
            o_in_position <= 1'b0;
            o_inhibit     <= '0;
        end else begin
            o_setpoint    <= next_setpoint;
            o_in_position <= next_in_position;
            o_inhibit     <= next_inhibit;
        end
    end

    // released task obeys the limits in force when it was taken
    property p_speed_clamp;
        @(posedge i_clock) disable iff (i_reset)
        o_task_valid |-> o_task.velocity <= $past(max_travel_speed);
    endproperty
    a_speed_clamp: assert property (p_speed_clamp)
        else $error("velocity above maximum");
    property p_ramp_floor;
        @(posedge i_clock) disable iff (i_reset)
        o_task_valid |-> (o_task.accel_time >= $past(min_ramp_time)
            && o_task.brake_time >= $past(min_ramp_time));
    endproperty
    a_ramp_floor: assert property (p_ramp_floor)
        else $error("ramp time below minimum");

    // absolute task beyond the modulo range, then the refusal
    sequence s_out_of_range;
        i_task_valid && i_modulo_axis && i_task.absolute && target_outside;
    endsequence
    property p_reject;
        @(posedge i_clock) disable iff (i_reset)
        s_out_of_range |=> (o_task_error && !o_task_valid);
    endproperty
    a_reject: assert property (p_reject)
        else $error("out of range task not rejected");

    // limit trips raise inhibit and emergency stop on the tick
    property p_limit1;
        @(posedge i_clock) disable iff (i_reset)
        (i_control_tick && limit1_hit) |=> o_inhibit.inhibit_neg
            && o_inhibit.emergency_stop;
    endproperty
    a_limit1: assert property (p_limit1)
        else $error("limit 1 did not inhibit");
    property p_limit2;
        @(posedge i_clock) disable iff (i_reset)
        (i_control_tick && limit2_hit) |=> o_inhibit.inhibit_pos
            && o_inhibit.emergency_stop;
    endproperty
    a_limit2: assert property (p_limit2)
        else $error("limit 2 did not inhibit");

    // configuration frozen while enabled, reserved bits stay clear
    property p_locked;
        @(posedge i_clock) disable iff (i_reset)
        (i_amp_enabled && i_config_write) |=>
        position_register_config == $past(position_register_config);
    endproperty
    a_locked: assert property (p_locked)
        else $error("config changed while enabled");
    property p_reserved;
        @(posedge i_clock) disable iff (i_reset)
        (position_register_config & `APLM_CFG_RESERVED) == 16'h0000;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bit set");

    // modulo setpoint falls back to range start at the end
    property p_wrap;
        @(posedge i_clock) disable iff (i_reset)
        (i_control_tick && i_modulo_axis
            && $signed(stepped[31:0]) >= $signed(wrap_range_end))
        |=> o_setpoint == $past(wrap_range_start);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("modulo position did not wrap");
endmodule // aplm_limit_monitor

// ==== rtl/aplm_map.svh ====
`ifndef APLM_MAP_SVH
`define APLM_MAP_SVH
// configuration word field positions, per register stride of four bits
`define APLM_CFG_STRIDE       4
`define APLM_CFG_ENABLE_BIT   0
`define APLM_CFG_POLARITY_BIT 1
`define APLM_CFG_LIMIT_BIT    2
`define APLM_CFG_RESERVED     16'hCC88
// reset values
`define APLM_RST_CONFIG       16'h0000
`define APLM_RST_THRESHOLD    32'h00000000
`define APLM_RST_MAX_SPEED    32'h00000064
`define APLM_RST_WINDOW       32'h00000FA0
`define APLM_RST_WRAP_START   32'h80000000
`define APLM_RST_WRAP_END     32'h7FFFFFFF
// timing: minimum ramp time default in microseconds, clock in kHz
`define APLM_MIN_RAMP_US      1000
`define APLM_CLOCK_KHZ        40000
`define APLM_MIN_RAMP_CYCLES  ((`APLM_MIN_RAMP_US * `APLM_CLOCK_KHZ) / 1000)
`endif

// ==== rtl/aplm_pkg.sv ====
package aplm_pkg;
    // unit for the ramp limit input
    typedef enum logic {
        APLM_UNIT_TIME,
        APLM_UNIT_ACCEL
    } aplm_accel_unit_t;

    // one motion task request from the task generator
    typedef struct packed {
        logic        absolute;
        logic [31:0] target;
        logic [31:0] velocity;
        logic [31:0] accel_time;
        logic [31:0] brake_time;
    } aplm_task_t;

    // task as released to the position controller
    typedef struct packed {
        logic [31:0] target;
        logic [31:0] velocity;
        logic [31:0] accel_time;
        logic [31:0] brake_time;
    } aplm_limited_t;

    // motion inhibits raised by the limit switches
    typedef struct packed {
        logic inhibit_neg;
        logic inhibit_pos;
        logic emergency_stop;
    } aplm_inhibit_t;
endpackage

// ==== rtl/aplm_pos_compare.sv ====
`include "aplm_map.svh"
// one position register comparator
module aplm_pos_compare (
    input  wire logic        i_clock,
    input  wire logic        i_reset,
    input  wire logic        i_sample,
    input  wire logic [3:0]  i_config,
    input  wire logic [31:0] i_threshold,
    input  wire logic [31:0] i_position,
    output logic             o_flag
);
    import aplm_pkg::*;
    logic next_flag;
    logic below;
    logic above;

    // signed compare; equal position raises neither side
    always_comb begin
        below = $signed(i_position) < $signed(i_threshold);
        above = $signed(i_position) > $signed(i_threshold);
        next_flag = o_flag;
        if (i_sample) begin
            if (!i_config[`APLM_CFG_ENABLE_BIT]) begin
                next_flag = 1'b0;
            end else if (i_config[`APLM_CFG_POLARITY_BIT]) begin
                next_flag = below;
            end else begin
                next_flag = above;
            end
        end
    end

    // flag refreshed once per control cycle
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            o_flag <= 1'b0;
        end else begin
            o_flag <= next_flag;
        end
    end

    // a disabled register reads clear after each sample
    property p_disabled_clear;
        @(posedge i_clock) disable iff (i_reset)
        (i_sample && !i_config[`APLM_CFG_ENABLE_BIT]) |=> !o_flag;
    endproperty
    a_disabled_clear: assert property (p_disabled_clear)
        else $error("disabled register raised its flag");

    // equal position raises neither polarity
    property p_polarity_ok;
        @(posedge i_clock) disable iff (i_reset)
        (i_sample && i_config[`APLM_CFG_ENABLE_BIT]) |=>
        (o_flag == ($past(i_config[`APLM_CFG_POLARITY_BIT]) ?
            ($signed($past(i_position)) < $signed($past(i_threshold))) :
            ($signed($past(i_position)) > $signed($past(i_threshold)))));
    endproperty
    a_polarity_ok: assert property (p_polarity_ok)
        else $error("flag does not follow compare polarity");
endmodule // aplm_pos_compare

// ==== tb/aplm_task_source.sv ====
// motion task generator and position controller loop on the far side
module aplm_task_source (
    input  wire logic            i_clock,
    output logic                 o_task_valid,
    output aplm_pkg::aplm_task_t o_task,
    output logic                 o_control_tick,
    output logic [31:0]          o_actual_position,
    output logic [31:0]          o_position_step
);
    timeunit 1ns;
    timeprecision 1ps;
    import aplm_pkg::*;

    // quiet bus at time zero
    initial begin
        o_task_valid = 1'b0;
        o_task = '0;
        o_control_tick = 1'b0;
        o_actual_position = 32'h00000000;
        o_position_step = 32'h00000000;
    end

    // one task pulse; released bus shows the inverse, never stale data
    task automatic send_task(input aplm_task_t t, input int gap);
        @(negedge i_clock);
        o_task <= t;
        o_task_valid <= 1'b1;
        @(negedge i_clock);
        o_task_valid <= 1'b0;
        o_task <= ~t;
        repeat (gap) @(negedge i_clock);
    endtask

    // one control cycle; position is a level and stays put
    task automatic tick(input logic [31:0] pos, input logic [31:0] step);
        @(negedge i_clock);
        o_actual_position <= pos;
        o_position_step <= step;
        o_control_tick <= 1'b1;
        @(negedge i_clock);
        o_control_tick <= 1'b0;
        o_position_step <= ~step;
    endtask
endmodule // aplm_task_source

// ==== tb/axis_position_limit_monitor_test.sv ====
module axis_position_limit_monitor_test;
    timeunit 1ns;
    timeprecision 1ps;
    import aplm_pkg::*;
    localparam int RAMP_MIN = 10;
    typedef struct {
        logic [31:0] vel, acc, brk, exp_vel, exp_acc, exp_brk;
    } aplm_row_t;
    // speed limit 500, minimum ramp 20 while these run
    aplm_row_t rows [4] = '{
        '{32'h12C, 32'h5, 32'h1E, 32'h12C, 32'h14, 32'h1E},
        '{32'h320, 32'h15, 32'h13, 32'h1F4, 32'h15, 32'h14},
        '{32'h1F4, 32'h14, 32'h0, 32'h1F4, 32'h14, 32'h14},
        '{32'h1F5, 32'h64, 32'h14, 32'h1F4, 32'h64, 32'h14}};
    logic [31:0] acc_in [3] = '{32'h32, 32'h3E8, 32'h0};
    logic [31:0] acc_exp [3] = '{32'hA, 32'h1, 32'hFFFFFFFF};
    logic [31:0] pos_in [4] = '{32'h96, 32'h64, 32'h1F4, 32'h0};
    logic [31:0] flag_exp [4] = '{32'h3, 32'h2, 32'h9, 32'h2};
    logic [31:0] win_pos [4] = '{32'h352, 32'h351, 32'h3B6, 32'h3B7};
    logic [31:0] lim_pos [3] = '{32'hFFFFFF38, 32'h0, 32'hC8};
    logic [31:0] lim_exp [3] = '{32'h5, 32'h0, 32'h3};
    logic [31:0] wrap_exp [4] = '{32'h3AC, 32'h3D4, 32'h0, 32'h28};
    logic clock = 1'b0, reset = 1'b1, param_write = 1'b0;
    logic config_write = 1'b0, thr_write = 1'b0, modulo = 1'b0;
    logic amp_en = 1'b0;
    logic [15:0] config_data = 16'h0000;
    logic [1:0] thr_index = 2'h0;
    logic [31:0] thr_data = 32'h0, max_accel = 32'h32, max_speed = 32'h1F4;
    aplm_accel_unit_t accel_unit = APLM_UNIT_TIME;
    logic task_valid, tick, lim_valid, lim_error, in_pos;
    aplm_task_t task_req;
    aplm_limited_t lim_task;
    aplm_inhibit_t inhibit;
    logic [31:0] act_pos, pos_step, setpoint, speed_rb, ramp_rb;
    logic [31:0] window_rb, wstart_rb, wend_rb;
    logic [3:0] flags;
    logic [15:0] cfg_rb;
    int n_mismatch = 0, checks_done = 0;

    initial begin
        forever #12.5 clock = ~clock;
    end

    aplm_task_source partner (.i_clock(clock), .o_task_valid(task_valid),
        .o_task(task_req), .o_control_tick(tick),
        .o_actual_position(act_pos), .o_position_step(pos_step));

    aplm_limit_monitor #(.REG_COUNT(4), .MIN_RAMP_DEFAULT(RAMP_MIN)) DUT (
        .i_clock(clock), .i_reset(reset), .i_param_write(param_write),
        .i_config_write(config_write), .i_config_data(config_data),
        .i_threshold_write(thr_write), .i_threshold_index(thr_index),
        .i_threshold_data(thr_data), .i_max_travel_speed(max_speed),
        .i_min_ramp_time(32'h14), .i_max_accel(max_accel),
        .i_accel_unit(accel_unit), .i_target_window(32'h32),
        .i_wrap_range_start(32'h0), .i_wrap_range_end(32'h3E8),
        .i_modulo_axis(modulo), .i_amp_enabled(amp_en),
        .i_task_valid(task_valid), .i_task(task_req),
        .i_control_tick(tick), .i_actual_position(act_pos),
        .i_position_step(pos_step), .o_task(lim_task),
        .o_task_valid(lim_valid), .o_task_error(lim_error),
        .o_in_position(in_pos), .o_setpoint(setpoint), .o_inhibit(inhibit),
        .o_threshold_flag(flags), .o_position_register_config(cfg_rb),
        .o_max_travel_speed(speed_rb), .o_min_ramp_time(ramp_rb),
        .o_target_window(window_rb), .o_wrap_range_start(wstart_rb),
        .o_wrap_range_end(wend_rb));

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // strobes last one cycle; one spare cycle lets readback settle
    task automatic strobe(input int which);
        param_write <= (which == 0);
        config_write <= (which == 1);
        thr_write <= (which == 2);
        @(negedge clock);
        {param_write, config_write, thr_write} <= 3'b000;
        @(negedge clock);
    endtask

    task automatic cfg(input logic [15:0] d);
        config_data <= d;
        strobe(1);
    endtask

    task automatic thr(input logic [1:0] i, input logic [31:0] d);
        thr_index <= i;
        thr_data <= d;
        strobe(2);
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        repeat (5000) @(posedge clock);
        n_mismatch++;
        give_verdict();
    end

    initial begin
        repeat (2) @(negedge clock);
        // defaults while reset is still asserted
        chk("config", 32'h0, {16'h0, cfg_rb});
        chk("speed", 32'h64, speed_rb);
        chk("ramp", 32'(RAMP_MIN), ramp_rb);
        chk("window", 32'hFA0, window_rb);
        chk("wrap start", 32'h80000000, wstart_rb);
        chk("wrap end", 32'h7FFFFFFF, wend_rb);
        chk("flags", 32'h0, {28'h0, flags});
        reset <= 1'b0;
        @(negedge clock);
        // acceleration unit: ratio, floor of one, zero saturates
        accel_unit <= APLM_UNIT_ACCEL;
        for (int i = 0; i < 3; i++) begin
            max_accel <= acc_in[i];
            strobe(0);
            chk("ramp accel", acc_exp[i], ramp_rb);
        end
        accel_unit <= APLM_UNIT_TIME;
        strobe(0);
        chk("ramp time", 32'h14, ramp_rb);
        chk("window", 32'h32, window_rb);
        chk("wrap end", 32'h3E8, wend_rb);
        chk("wrap start", 32'h0, wstart_rb);
        chk("speed", 32'h1F4, speed_rb);
        for (int i = 0; i < 4; i++) begin
            partner.send_task('{1'b1, 32'h64, rows[i].vel, rows[i].acc,
                                rows[i].brk}, 0);
            chk("valid", 32'h1, {31'h0, lim_valid});
            chk("velocity", rows[i].exp_vel, lim_task.velocity);
            chk("accel", rows[i].exp_acc, lim_task.accel_time);
            chk("brake", rows[i].exp_brk, lim_task.brake_time);
            chk("target", 32'h64, lim_task.target);
        end
        // lower maximum overrides a faster task
        max_speed <= 32'h64;
        strobe(0);
        chk("low speed", 32'h64, speed_rb);
        partner.send_task('{1'b1, 32'h64, 32'h12C, 32'h14, 32'h14}, 0);
        chk("slow velocity", 32'h64, lim_task.velocity);
        // reserved bits never stick; set up only while disabled
        cfg(16'hFFFF);
        chk("reserved", 32'h3377, {16'h0, cfg_rb});
        cfg(16'h1031);
        for (int i = 0; i < 4; i++) begin
            thr(2'(i), 32'h64 * (i + 1));
        end
        for (int i = 0; i < 4; i++) begin
            partner.tick(pos_in[i], 32'h0);
            chk("flags", flag_exp[i], {28'h0, flags});
        end
        // enabled amplifier refuses configuration
        amp_en <= 1'b1;
        cfg(16'h0000);
        thr(2'h0, 32'h0);
        partner.tick(32'h96, 32'h0);
        chk("locked", 32'h1031, {16'h0, cfg_rb});
        chk("locked flags", 32'h3, {28'h0, flags});
        amp_en <= 1'b0;
        // limit switches on registers 1 and 2
        cfg(16'h0055);
        thr(2'h0, 32'hFFFFFF9C);
        thr(2'h1, 32'h64);
        for (int i = 0; i < 3; i++) begin
            partner.tick(lim_pos[i], 32'h0);
            chk("inhibit", lim_exp[i], {29'h0, inhibit});
        end
        // limit bit without enable, register 3 cannot be a limit
        cfg(16'h0504);
        partner.tick(32'hFFFFFF38, 32'h0);
        chk("no limit", 32'h0, {29'h0, inhibit});
        partner.send_task('{1'b1, 32'h384, 32'h64, 32'h14, 32'h14}, 2);
        for (int i = 0; i < 4; i++) begin
            partner.tick(win_pos[i], 32'h0);
            chk("in position", 32'(i % 2 == 0), {31'h0, in_pos});
            chk("setpoint", 32'h384, setpoint);
        end
        // modulo: out of range target refused, setpoint wraps at end
        modulo <= 1'b1;
        partner.send_task('{1'b1, 32'h5DC, 32'h64, 32'h14, 32'h14}, 0);
        chk("task error", 32'h1, {31'h0, lim_error});
        chk("task valid", 32'h0, {31'h0, lim_valid});
        for (int i = 0; i < 4; i++) begin
            partner.tick(32'h384, 32'h28);
            chk("wrap", wrap_exp[i], setpoint);
        end
        // mid-run reset; threshold 1 left at -100 would flag -50
        reset <= 1'b1;
        @(negedge clock);
        chk("reset config", 32'h0, {16'h0, cfg_rb});
        chk("reset setpoint", 32'h0, setpoint);
        chk("reset speed", 32'h64, speed_rb);
        reset <= 1'b0;
        @(negedge clock);
        cfg(16'h0001);
        partner.tick(32'hFFFFFFCE, 32'h0);
        chk("reset threshold", 32'h0, {28'h0, flags});
        give_verdict();
    end
endmodule // axis_position_limit_monitor_test
